// [leol_pkg.sv]
// shared constants, command codes and carrier types for the limit and event output logic
`default_nettype none
package leol_pkg;

	// word widths
	localparam int unsigned LEOL_DW = 16;
	localparam int unsigned LEOL_NEVT = 16;

	// event positions inside the 16-bit event vector
	localparam logic [3:0] LEOL_EVT_IDLE = 4'h0;
	localparam logic [3:0] LEOL_EVT_IIN = 4'h1;
	localparam logic [3:0] LEOL_EVT_VIN = 4'h2;

	// force codes, two-bit two's complement
	localparam logic [1:0] LEOL_FORCE_EVENT = 2'h3;
	localparam logic [1:0] LEOL_FORCE_OFF = 2'h0;
	localparam logic [1:0] LEOL_FORCE_ON = 2'h1;

	// reset values
	localparam logic [1:0] LEOL_RLY_FORCE_RST = 2'h3;
	localparam logic [15:0] LEOL_RLY_EN_RST = 16'h0000;
	localparam logic [15:0] LEOL_THR_RST = 16'h0000;
	localparam logic [15:0] LEOL_HYST_RST = 16'h0000;
	localparam logic [15:0] LEOL_IDLE_TMO_RST = 16'h0001;

	// timing: one second of idle time at 100 MHz
	localparam int unsigned LEOL_CLK_HZ = 100_000_000;
	localparam int unsigned LEOL_SEC_S = 1;
	localparam int unsigned LEOL_CYC_PER_SEC = LEOL_CLK_HZ * LEOL_SEC_S;

	// items reachable by a write or a query
	typedef enum logic [3:0] {
		LEOL_SEL_VLO_EN = 4'b0000,
		LEOL_SEL_VLO_THR = 4'b0001,
		LEOL_SEL_VHYST = 4'b0010,
		LEOL_SEL_PIN_LEVEL = 4'b0011,
		LEOL_SEL_RLY_EN = 4'b0100,
		LEOL_SEL_RLY_COND = 4'b0101,
		LEOL_SEL_RLY_FORCE = 4'b0110,
		LEOL_SEL_IDLE_TMO = 4'b0111,
		LEOL_SEL_IHI_EN = 4'b1000,
		LEOL_SEL_IHI_THR = 4'b1001,
		LEOL_SEL_IHYST = 4'b1010
	} leol_sel_t;

	// one command from the host side
	typedef struct packed {
		leol_sel_t sel;
		logic has_idx;
		logic [3:0] idx;
		logic [15:0] data;
	} leol_cmd_t;

	// one limit comparator setting
	typedef struct packed {
		logic en;
		logic [15:0] thr;
		logic [15:0] hyst;
	} leol_limit_cfg_t;

endpackage
`default_nettype wire

// [leol_limit_cmp.sv]
// limit comparator with hysteresis, low or high side
`timescale 1ns/1ps
`default_nettype none
module leol_limit_cmp import leol_pkg::*; #(
	parameter bit HIGH_SIDE = 1'b0
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic sample_valid_i, // new reading this cycle
	input wire logic [15:0] sample_i, // reading, as a magnitude
	input wire leol_limit_cfg_t cfg_i, // enable, threshold, hysteresis
	output logic cond_d_o, // condition as of this cycle
	output logic cond_q_o // registered condition
);
	logic [16:0] rel_hi;
	logic [16:0] rel_lo;
	logic cond_q;

	// release points; the low one saturates at zero so a large hysteresis cannot wrap
	assign rel_hi = {1'b0, cfg_i.thr} + {1'b0, cfg_i.hyst};
	assign rel_lo = (cfg_i.thr >= cfg_i.hyst) ? {1'b0, cfg_i.thr - cfg_i.hyst} : 17'h00000;

	// set on crossing, clear only once back inside by the hysteresis
	always_comb begin
		cond_d_o = cond_q;
		if (!cfg_i.en) begin
			cond_d_o = 1'b0;
		end else if (sample_valid_i) begin // RULE20
			if (HIGH_SIDE) begin
				if (sample_i > cfg_i.thr) begin // RULE19
					cond_d_o = 1'b1;
				end else if ({1'b0, sample_i} < rel_lo) begin // RULE18
					cond_d_o = 1'b0;
				end
			end else begin
				if (sample_i < cfg_i.thr) begin // RULE2
					cond_d_o = 1'b1;
				end else if ({1'b0, sample_i} > rel_hi) begin // RULE18
					cond_d_o = 1'b0;
				end
			end
		end
	end

	// condition state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cond_q <= 1'b0;
		end else begin
			cond_q <= cond_d_o;
		end
	end

	assign cond_q_o = cond_q;
endmodule
`default_nettype wire

// [leol_idle_timer.sv]
// host-link idle timer counting whole seconds since the last traffic
`timescale 1ns/1ps
`default_nettype none
module leol_idle_timer import leol_pkg::*; #(
	parameter int unsigned CYC_PER_SEC = LEOL_CYC_PER_SEC
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic traffic_i, // host traffic seen this cycle
	input wire logic [15:0] timeout_i, // timeout in seconds, above zero
	output logic idle_d_o, // idle condition as of this cycle
	output logic idle_q_o // registered idle condition
);
	logic [31:0] sub_q;
	logic [15:0] sec_q;
	logic tick;
	logic idle_q;

	assign tick = (sub_q == 32'(CYC_PER_SEC - 1)) && !traffic_i;

	// prescaler down to one tick per second; traffic restarts it
	always_ff @(posedge clk_i) begin
		if (rst_i || traffic_i) begin // RULE15
			sub_q <= 32'h00000000;
		end else if (tick) begin
			sub_q <= 32'h00000000;
		end else begin
			sub_q <= sub_q + 32'h00000001;
		end
	end

	// whole seconds elapsed, saturating so a long silence never wraps back to busy
	always_ff @(posedge clk_i) begin
		if (rst_i || traffic_i) begin // RULE15
			sec_q <= 16'h0000;
		end else if (tick && (sec_q != 16'hFFFF)) begin
			sec_q <= sec_q + 16'h0001;
		end
	end

	// met one cycle after the full timeout has elapsed, so strictly longer than it
	assign idle_d_o = !traffic_i && (sec_q >= timeout_i); // RULE14

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_q <= 1'b0;
		end else begin
			idle_q <= idle_d_o;
		end
	end

	assign idle_q_o = idle_q;
endmodule
`default_nettype wire

// [leol_top.sv]
// limit and event logic driving the output pin and the relay, with its command port
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: query returns voltage low limit enable bit
// RULE2: voltage below threshold sets pin event condition
// RULE3: pin level query returns driven output level
// RULE4: pin low when forced low or no event
// RULE5: pin high when forced high or event met
// RULE6: indexed write updates one relay enable bit
// RULE7: mask write replaces all sixteen relay enables
// RULE8: enable query returns one bit or mask
// RULE9: condition query returns enabled detected conditions
// RULE10: disabled events always report condition zero
// RULE11: relay force accepts event, off, on
// RULE12: event mode turns relay on for conditions
// RULE13: force query returns stored force value
// RULE14: idle met after silence longer than timeout
// RULE15: host traffic clears idle and restarts timer
// RULE16: current high enable gates relay current event
// RULE17: query returns current high limit enable bit
// RULE18: limit clears only past hysteresis band
// RULE19: current magnitude above threshold meets condition
// RULE20: sample updates conditions and outputs together
module leol_top import leol_pkg::*; #(
	parameter int unsigned CYC_PER_SEC = LEOL_CYC_PER_SEC
) (
	input wire logic SYS_CLK_I, // system clock, 100 MHz
	input wire logic RST_I, // synchronous reset, active high
	input wire logic WR_VALID_I, // write command strobe
	input wire leol_cmd_t WR_CMD_I, // write command
	input wire logic QRY_VALID_I, // query command strobe
	input wire leol_cmd_t QRY_CMD_I, // query command, data unused
	input wire logic VIN_VALID_I, // new voltage reading
	input wire logic [15:0] VIN_I, // voltage reading, non-negative
	input wire logic IIN_VALID_I, // new current reading
	input wire logic signed [15:0] IIN_I, // current reading, signed
	input wire logic HOST_TRAFFIC_I, // traffic seen on any host link
	input wire logic [15:0] EXT_COND_I, // raw conditions of other events
	input wire logic [15:0] PIN_EVT_EN_I, // events monitored by the pin
	input wire logic [1:0] PIN_FORCE_I, // pin force code, -1 event
	input wire logic PIN_DIR_I, // pin direction, 1 output
	output logic PIN_O, // pin output level
	output logic PIN_OE_N_O, // pin output enable, low drives
	output logic RELAY_ON_O, // relay position, 1 on
	output logic [15:0] RLY_COND_O, // relay condition mask
	output logic QRY_ACK_O, // query answer strobe
	output logic [15:0] QRY_DATA_O // query answer
);
	leol_limit_cfg_t vlo_cfg_q;
	leol_limit_cfg_t ihi_cfg_q;
	logic [15:0] rly_en_q;
	logic [1:0] rly_force_q;
	logic [15:0] idle_tmo_q;
	logic [15:0] raw_d;
	logic [15:0] rly_cond_d;
	logic [15:0] rly_cond_q;
	logic [15:0] pin_cond_d;
	logic [15:0] iin_mag;
	logic vlo_cond_d;
	logic ihi_cond_d;
	logic idle_cond_d;
	logic pin_d;
	logic pin_q;
	logic relay_d;
	logic relay_q;
	logic oe_n_q;
	logic ack_q;
	logic [15:0] qry_q;
	logic [15:0] qry_d;
	logic wr_vlo_en;
	logic wr_vlo_thr;
	logic wr_vhyst;
	logic wr_rly_en;
	logic wr_rly_force;
	logic wr_idle;
	logic wr_ihi_en;
	logic wr_ihi_thr;
	logic wr_ihyst;

	// write decode
	assign wr_vlo_en = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_VLO_EN);
	assign wr_vlo_thr = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_VLO_THR);
	assign wr_vhyst = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_VHYST);
	assign wr_rly_en = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_RLY_EN);
	assign wr_rly_force = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_RLY_FORCE);
	assign wr_idle = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_IDLE_TMO);
	assign wr_ihi_en = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_IHI_EN);
	assign wr_ihi_thr = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_IHI_THR);
	assign wr_ihyst = WR_VALID_I && (WR_CMD_I.sel == LEOL_SEL_IHYST);

	// voltage low limit setting; enable takes only bit 0 of the data
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			vlo_cfg_q <= '{en: 1'b0, thr: LEOL_THR_RST, hyst: LEOL_HYST_RST};
		end else begin
			if (wr_vlo_en) begin
				vlo_cfg_q.en <= WR_CMD_I.data[0];
			end
			if (wr_vlo_thr) begin
				vlo_cfg_q.thr <= WR_CMD_I.data;
			end
			if (wr_vhyst) begin
				vlo_cfg_q.hyst <= WR_CMD_I.data;
			end
		end
	end

	// current high limit setting
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			ihi_cfg_q <= '{en: 1'b0, thr: LEOL_THR_RST, hyst: LEOL_HYST_RST};
		end else begin
			if (wr_ihi_en) begin
				ihi_cfg_q.en <= WR_CMD_I.data[0]; // RULE16
			end
			if (wr_ihi_thr) begin
				ihi_cfg_q.thr <= WR_CMD_I.data;
			end
			if (wr_ihyst) begin
				ihi_cfg_q.hyst <= WR_CMD_I.data;
			end
		end
	end

	// relay enable mask: indexed write touches one bit, plain write replaces all
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			rly_en_q <= LEOL_RLY_EN_RST;
		end else if (wr_rly_en) begin
			if (WR_CMD_I.has_idx) begin
				rly_en_q[WR_CMD_I.idx] <= WR_CMD_I.data[0]; // RULE6
			end else begin
				rly_en_q <= WR_CMD_I.data; // RULE7
			end
		end
	end

	// relay force; code -2 is not a legal setting and leaves the value unchanged
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			rly_force_q <= LEOL_RLY_FORCE_RST;
		end else if (wr_rly_force && (WR_CMD_I.data[1:0] != 2'h2)) begin
			rly_force_q <= WR_CMD_I.data[1:0]; // RULE11
		end
	end

	// idle timeout; zero is refused since the timer would report idle at once
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			idle_tmo_q <= LEOL_IDLE_TMO_RST;
		end else if (wr_idle && (WR_CMD_I.data != 16'h0000)) begin
			idle_tmo_q <= WR_CMD_I.data; // RULE14
		end
	end

	// current readings are compared as magnitudes; the most negative value saturates
	always_comb begin
		if (!IIN_I[15]) begin
			iin_mag = IIN_I;
		end else if (IIN_I == 16'h8000) begin
			iin_mag = 16'h7FFF;
		end else begin
			iin_mag = 16'(-IIN_I); // RULE19
		end
	end

	leol_limit_cmp #(
		.HIGH_SIDE(1'b0)
	) u_vlo_cmp (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.sample_valid_i(VIN_VALID_I),
		.sample_i(VIN_I),
		.cfg_i(vlo_cfg_q),
		.cond_d_o(vlo_cond_d),
		.cond_q_o()
	);

	leol_limit_cmp #(
		.HIGH_SIDE(1'b1)
	) u_ihi_cmp (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.sample_valid_i(IIN_VALID_I),
		.sample_i(iin_mag),
		.cfg_i(ihi_cfg_q),
		.cond_d_o(ihi_cond_d),
		.cond_q_o()
	);

	leol_idle_timer #(
		.CYC_PER_SEC(CYC_PER_SEC)
	) u_idle (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.traffic_i(HOST_TRAFFIC_I),
		.timeout_i(idle_tmo_q),
		.idle_d_o(idle_cond_d),
		.idle_q_o()
	);

	// raw event vector: internal events take their slots, the rest come from outside
	genvar gi;
	generate
		for (gi = 0; gi < LEOL_NEVT; gi++) begin : g_raw
			if (gi == LEOL_EVT_IDLE) begin : g_idle
				assign raw_d[gi] = idle_cond_d; // RULE15
			end else if (gi == LEOL_EVT_IIN) begin : g_iin
				assign raw_d[gi] = ihi_cond_d; // RULE16
			end else if (gi == LEOL_EVT_VIN) begin : g_vin
				assign raw_d[gi] = vlo_cond_d; // RULE2
			end else begin : g_ext
				assign raw_d[gi] = EXT_COND_I[gi];
			end
		end
	endgenerate

	// conditions of events that are not enabled always read as zero
	assign rly_cond_d = raw_d & rly_en_q; // RULE10
	assign pin_cond_d = raw_d & PIN_EVT_EN_I;

	// pin level from force code or from any monitored condition
	always_comb begin
		unique case (PIN_FORCE_I)
			LEOL_FORCE_OFF: pin_d = 1'b0; // RULE4
			LEOL_FORCE_ON: pin_d = 1'b1; // RULE5
			default: pin_d = |pin_cond_d; // RULE4 RULE5
		endcase
	end

	// relay position; clearing idle alone drops the relay when nothing else holds it
	always_comb begin
		unique case (rly_force_q)
			LEOL_FORCE_OFF: relay_d = 1'b0; // RULE11
			LEOL_FORCE_ON: relay_d = 1'b1; // RULE11
			default: relay_d = |rly_cond_d; // RULE12 RULE15
		endcase
	end

	// outputs take the same edge as the conditions, no extra cycle of lag
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			pin_q <= 1'b0;
			oe_n_q <= 1'b1;
			relay_q <= 1'b0;
			rly_cond_q <= 16'h0000;
		end else begin
			pin_q <= pin_d; // RULE20
			oe_n_q <= !PIN_DIR_I;
			relay_q <= relay_d; // RULE20
			rly_cond_q <= rly_cond_d; // RULE20
		end
	end

	// query answer mux over registered state
	always_comb begin
		qry_d = 16'h0000;
		unique case (QRY_CMD_I.sel)
			LEOL_SEL_VLO_EN: qry_d = {15'h0000, vlo_cfg_q.en}; // RULE1
			LEOL_SEL_VLO_THR: qry_d = vlo_cfg_q.thr;
			LEOL_SEL_VHYST: qry_d = vlo_cfg_q.hyst;
			LEOL_SEL_PIN_LEVEL: qry_d = {15'h0000, pin_q && !oe_n_q}; // RULE3
			LEOL_SEL_RLY_EN: begin
				if (QRY_CMD_I.has_idx) begin
					qry_d = {15'h0000, rly_en_q[QRY_CMD_I.idx]}; // RULE8
				end else begin
					qry_d = rly_en_q; // RULE8
				end
			end
			LEOL_SEL_RLY_COND: begin
				if (QRY_CMD_I.has_idx) begin
					qry_d = {15'h0000, rly_cond_q[QRY_CMD_I.idx]}; // RULE9
				end else begin
					qry_d = rly_cond_q; // RULE9
				end
			end
			LEOL_SEL_RLY_FORCE: qry_d = {{14{rly_force_q[1]}}, rly_force_q}; // RULE13
			LEOL_SEL_IDLE_TMO: qry_d = idle_tmo_q;
			LEOL_SEL_IHI_EN: qry_d = {15'h0000, ihi_cfg_q.en}; // RULE17
			LEOL_SEL_IHI_THR: qry_d = ihi_cfg_q.thr;
			LEOL_SEL_IHYST: qry_d = ihi_cfg_q.hyst;
			default: qry_d = 16'h0000;
		endcase
	end

	// answer one cycle after the query; data holds until the next query
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			ack_q <= 1'b0;
			qry_q <= 16'h0000;
		end else begin
			ack_q <= QRY_VALID_I;
			if (QRY_VALID_I) begin
				qry_q <= qry_d;
			end
		end
	end

	assign PIN_O = pin_q;
	assign PIN_OE_N_O = oe_n_q;
	assign RELAY_ON_O = relay_q;
	assign RLY_COND_O = rly_cond_q;
	assign QRY_ACK_O = ack_q;
	assign QRY_DATA_O = qry_q;
endmodule
`default_nettype wire

// [leol_pkg_unused_guard.sv]
// no logic of its own: the shared items of the block live in the package
`default_nettype none
`default_nettype wire

// [leol_top_asserts.sv]
// port checker for the limit and event output logic
`timescale 1ns/1ps
`default_nettype none
module leol_top_asserts import leol_pkg::*; (
	input wire logic SYS_CLK_I, // system clock
	input wire logic RST_I, // synchronous reset
	input wire logic QRY_VALID_I, // query strobe
	input wire leol_cmd_t QRY_CMD_I, // query command
	input wire logic HOST_TRAFFIC_I, // host traffic
	input wire logic [15:0] EXT_COND_I, // raw conditions
	input wire logic [15:0] PIN_EVT_EN_I, // pin events
	input wire logic [1:0] PIN_FORCE_I, // pin force code
	input wire logic PIN_DIR_I, // pin direction
	input wire logic PIN_O, // pin level
	input wire logic PIN_OE_N_O, // pin enable, low drives
	input wire logic [15:0] RLY_COND_O, // relay conditions
	input wire logic QRY_ACK_O, // answer strobe
	input wire logic [15:0] QRY_DATA_O // answer
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	// queries answered exactly one cycle later, data held otherwise
	property p_ack; QRY_VALID_I |=> QRY_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("query not answered");
	property p_hold; !QRY_VALID_I |=> !QRY_ACK_O && $stable(QRY_DATA_O); endproperty
	a_hold: assert property (p_hold) else $error("answer without query");
	// forced pin levels
	property p_pin_lo; PIN_FORCE_I == 2'h0 |=> !PIN_O; endproperty
	a_pin_lo: assert property (p_pin_lo) else $error("pin not low when forced");
	property p_pin_hi; PIN_FORCE_I == 2'h1 |=> PIN_O; endproperty
	a_pin_hi: assert property (p_pin_hi) else $error("pin not high when forced");
	// event mode, only the outside events are visible here
	property p_evt_lo; PIN_FORCE_I[1] && PIN_EVT_EN_I == 16'h0000 |=> !PIN_O; endproperty
	a_evt_lo: assert property (p_evt_lo) else $error("pin high with no events");
	property p_evt_hi; PIN_FORCE_I[1] && |(EXT_COND_I & PIN_EVT_EN_I & 16'hFFF8) |=> PIN_O; endproperty
	a_evt_hi: assert property (p_evt_hi) else $error("pin low with event met");
	property p_oe; PIN_DIR_I |=> !PIN_OE_N_O; endproperty
	a_oe: assert property (p_oe) else $error("output pin not driven");
	property p_oe_off; !PIN_DIR_I |=> PIN_OE_N_O; endproperty
	a_oe_off: assert property (p_oe_off) else $error("input pin driven");
	property p_traffic; HOST_TRAFFIC_I |=> !RLY_COND_O[0]; endproperty
	a_traffic: assert property (p_traffic) else $error("idle kept through traffic");
	property p_cond_sub; 1'b1 |=> (RLY_COND_O & ~$past(EXT_COND_I) & 16'hFFF8) == 16'h0000; endproperty
	a_cond_sub: assert property (p_cond_sub) else $error("condition without cause");
	property p_cond_qry;
		QRY_VALID_I && QRY_CMD_I.sel == LEOL_SEL_RLY_COND && !QRY_CMD_I.has_idx |=> QRY_DATA_O == $past(RLY_COND_O);
	endproperty
	a_cond_qry: assert property (p_cond_qry) else $error("condition mask answer wrong");
	// stable forced level on a driven pin must be read back
	property p_lvl;
		QRY_VALID_I && QRY_CMD_I.sel == LEOL_SEL_PIN_LEVEL && !PIN_OE_N_O && !PIN_FORCE_I[1] && $stable(PIN_FORCE_I)
		|=> QRY_DATA_O == {15'h0000, $past(PIN_FORCE_I[0])};
	endproperty
	a_lvl: assert property (p_lvl) else $error("pin level answer wrong");
endmodule
bind leol_top leol_top_asserts i_leol_top_asserts (.SYS_CLK_I, .RST_I, .QRY_VALID_I, .QRY_CMD_I, .HOST_TRAFFIC_I,
	.EXT_COND_I, .PIN_EVT_EN_I, .PIN_FORCE_I, .PIN_DIR_I, .PIN_O, .PIN_OE_N_O, .RLY_COND_O, .QRY_ACK_O, .QRY_DATA_O);
`default_nettype wire

// [leol_host_model.sv]
// host model issuing write and query commands
`timescale 1ns/1ps
`default_nettype none
module leol_host_model import leol_pkg::*; (
	input wire logic clk_i, // system clock
	input wire logic qry_ack_i, // answer strobe
	input wire logic [15:0] qry_data_i, // answer
	output leol_cmd_t wr_cmd_o, // write command
	output logic wr_valid_o, // write strobe
	output leol_cmd_t qry_cmd_o, // query command
	output logic qry_valid_o // query strobe
);
	initial begin
		wr_cmd_o = '0;
		wr_valid_o = 1'b0;
		qry_cmd_o = '0;
		qry_valid_o = 1'b0;
	end
	// one write held across one rising edge, then the command is scrambled
	task automatic wr(input leol_sel_t s, input logic hi, input logic [3:0] ix, input logic [15:0] d);
		@(negedge clk_i);
		wr_cmd_o = '{s, hi, ix, d};
		wr_valid_o = 1'b1;
		@(negedge clk_i);
		wr_valid_o = 1'b0;
		wr_cmd_o = ~wr_cmd_o; // stale fields must not matter
	endtask
	// missing answer comes back unknown so that any compare fails
	task automatic qry(input leol_sel_t s, input logic hi, input logic [3:0] ix, output logic [15:0] d);
		@(negedge clk_i);
		qry_cmd_o = '{s, hi, ix, 16'h0000};
		qry_valid_o = 1'b1;
		@(negedge clk_i);
		qry_valid_o = 1'b0;
		qry_cmd_o = ~qry_cmd_o;
		d = (qry_ack_i === 1'b1) ? qry_data_i : 16'hXXXX;
	endtask
endmodule
`default_nettype wire

// [leol_top_tb_top.sv]
// self-checking bench for the limit and event output logic
`timescale 1ns/1ps
`default_nettype none
module leol_top_tb_top import leol_pkg::*;;
	logic clk, rst, wv, qv, vv, iv, trf, dir, pin, oe_n, rly, ack;
	leol_cmd_t wc, qc;
	logic [15:0] vin, iin, ext, pen, cond, qd;
	logic [1:0] pf;
	int errors = 0;
	int comparisons = 0;
	leol_top #(.CYC_PER_SEC(10)) i_leol_top (.SYS_CLK_I(clk), .RST_I(rst), .WR_VALID_I(wv), .WR_CMD_I(wc),
		.QRY_VALID_I(qv), .QRY_CMD_I(qc), .VIN_VALID_I(vv), .VIN_I(vin), .IIN_VALID_I(iv), .IIN_I(iin),
		.HOST_TRAFFIC_I(trf), .EXT_COND_I(ext), .PIN_EVT_EN_I(pen), .PIN_FORCE_I(pf), .PIN_DIR_I(dir),
		.PIN_O(pin), .PIN_OE_N_O(oe_n), .RELAY_ON_O(rly), .RLY_COND_O(cond), .QRY_ACK_O(ack), .QRY_DATA_O(qd));
	leol_host_model i_leol_host_model (.clk_i(clk), .qry_ack_i(ack), .qry_data_i(qd), .wr_cmd_o(wc),
		.wr_valid_o(wv), .qry_cmd_o(qc), .qry_valid_o(qv));
	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic give_verdict();
		if (errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic q(input leol_sel_t s, input logic hi, input logic [3:0] ix, input logic [15:0] exp);
		logic [15:0] d;
		i_leol_host_model.qry(s, hi, ix, d);
		chk(d, exp);
	endtask
	task automatic w(input leol_sel_t s, input logic hi, input logic [3:0] ix, input logic [15:0] d);
		i_leol_host_model.wr(s, hi, ix, d);
	endtask
	// one sample pulse, reading scrambled after release
	task automatic smp(input logic cur, input logic [15:0] v);
		@(negedge clk);
		vin = v;
		iin = v;
		vv = !cur;
		iv = cur;
		@(negedge clk);
		vv = 1'b0;
		iv = 1'b0;
		vin = ~v;
		iin = ~v;
	endtask
	task automatic t_reset_vals();
		q(LEOL_SEL_RLY_FORCE, 1'b0, 4'h0, 16'hFFFF);
		q(LEOL_SEL_RLY_EN, 1'b0, 4'h0, 16'h0000);
		q(LEOL_SEL_VLO_EN, 1'b0, 4'h0, 16'h0000);
		q(LEOL_SEL_IHI_EN, 1'b0, 4'h0, 16'h0000);
		q(LEOL_SEL_IDLE_TMO, 1'b0, 4'h0, 16'h0001);
	endtask
	// off, on, event, then the refused code leaves event mode in place
	task automatic t_force();
		logic [1:0] code[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
		logic [15:0] fexp[4] = '{16'h0000, 16'h0001, 16'hFFFF, 16'hFFFF};
		for (int k = 0; k < 4; k++) begin
			w(LEOL_SEL_RLY_FORCE, 1'b0, 4'h0, {14'h0000, code[k]});
			@(negedge clk);
			chk({15'h0000, rly}, {15'h0000, code[k] == 2'h1});
			q(LEOL_SEL_RLY_FORCE, 1'b0, 4'h0, fexp[k]);
		end
	endtask
	task automatic t_enables();
		w(LEOL_SEL_RLY_EN, 1'b0, 4'h0, 16'hFFFF);
		q(LEOL_SEL_RLY_EN, 1'b0, 4'h0, 16'hFFFF);
		w(LEOL_SEL_RLY_EN, 1'b0, 4'h0, 16'h0005);
		w(LEOL_SEL_RLY_EN, 1'b1, 4'hF, 16'h0001);
		w(LEOL_SEL_RLY_EN, 1'b1, 4'h0, 16'h0000);
		q(LEOL_SEL_RLY_EN, 1'b0, 4'h0, 16'h8004);
		q(LEOL_SEL_RLY_EN, 1'b1, 4'hF, 16'h0001);
		q(LEOL_SEL_RLY_EN, 1'b1, 4'h1, 16'h0000);
	endtask
	task automatic t_ext();
		w(LEOL_SEL_RLY_EN, 1'b0, 4'h0, 16'h0010);
		ext = 16'h0030;
		pen = 16'h0010;
		repeat (2) @(negedge clk);
		chk(cond, 16'h0010);
		chk({15'h0000, rly}, 16'h0001);
		q(LEOL_SEL_RLY_COND, 1'b0, 4'h0, 16'h0010);
		q(LEOL_SEL_RLY_COND, 1'b1, 4'h5, 16'h0000);
		q(LEOL_SEL_RLY_COND, 1'b1, 4'h4, 16'h0001);
		ext = 16'h0000;
		repeat (2) @(negedge clk);
		chk({15'h0000, rly}, 16'h0000);
	endtask
	// low limit 5 with hysteresis 1 on the pin
	task automatic t_vin();
		dir = 1'b1;
		pen = 16'h0004;
		w(LEOL_SEL_VLO_THR, 1'b0, 4'h0, 16'h0005);
		w(LEOL_SEL_VHYST, 1'b0, 4'h0, 16'h0001);
		w(LEOL_SEL_VLO_EN, 1'b0, 4'h0, 16'h0001);
		q(LEOL_SEL_VLO_EN, 1'b0, 4'h0, 16'h0001);
		q(LEOL_SEL_VLO_THR, 1'b0, 4'h0, 16'h0005);
		q(LEOL_SEL_VHYST, 1'b0, 4'h0, 16'h0001);
		smp(1'b0, 16'h0003);
		chk({15'h0000, pin}, 16'h0001);
		q(LEOL_SEL_PIN_LEVEL, 1'b0, 4'h0, 16'h0001);
		smp(1'b0, 16'h0006);
		chk({15'h0000, pin}, 16'h0001);
		smp(1'b0, 16'h0007);
		chk({15'h0000, pin}, 16'h0000);
		q(LEOL_SEL_PIN_LEVEL, 1'b0, 4'h0, 16'h0000);
		pf = 2'h1;
		q(LEOL_SEL_PIN_LEVEL, 1'b0, 4'h0, 16'h0001);
		pf = 2'h0;
		q(LEOL_SEL_PIN_LEVEL, 1'b0, 4'h0, 16'h0000);
		pf = 2'h3;
	endtask
	// high limit 10 with hysteresis 2, reading given negative
	task automatic t_iin();
		w(LEOL_SEL_RLY_EN, 1'b0, 4'h0, 16'h0002);
		w(LEOL_SEL_IHI_THR, 1'b0, 4'h0, 16'h000A);
		w(LEOL_SEL_IHYST, 1'b0, 4'h0, 16'h0002);
		w(LEOL_SEL_IHI_EN, 1'b0, 4'h0, 16'h0001);
		q(LEOL_SEL_IHI_EN, 1'b0, 4'h0, 16'h0001);
		q(LEOL_SEL_IHI_THR, 1'b0, 4'h0, 16'h000A);
		q(LEOL_SEL_IHYST, 1'b0, 4'h0, 16'h0002);
		smp(1'b1, 16'hFFF5);
		chk(cond, 16'h0002);
		chk({15'h0000, rly}, 16'h0001);
		smp(1'b1, 16'h0009);
		chk(cond, 16'h0002);
		w(LEOL_SEL_IHI_EN, 1'b0, 4'h0, 16'h0000);
		@(negedge clk);
		chk(cond, 16'h0000);
	endtask
	// two seconds of ten cycles each
	task automatic t_idle();
		int n;
		w(LEOL_SEL_IDLE_TMO, 1'b0, 4'h0, 16'h0002);
		w(LEOL_SEL_IDLE_TMO, 1'b0, 4'h0, 16'h0000);
		q(LEOL_SEL_IDLE_TMO, 1'b0, 4'h0, 16'h0002);
		w(LEOL_SEL_RLY_EN, 1'b0, 4'h0, 16'h0001);
		trf = 1'b1;
		@(negedge clk);
		trf = 1'b0;
		// still quiet at exactly the timeout, met one cycle past it
		repeat (20) @(negedge clk);
		chk(cond, 16'h0000);
		for (n = 0; n < 20 && cond[0] !== 1'b1; n++) @(negedge clk);
		if (n == 20) begin
			errors++;
			give_verdict();
		end
		chk(16'(n), 16'h0001);
		chk({15'h0000, rly}, 16'h0001);
		trf = 1'b1;
		@(negedge clk);
		trf = 1'b0;
		chk(cond, 16'h0000);
		chk({15'h0000, rly}, 16'h0000);
	endtask
	// main sequence, reset held five cycles
	initial begin
		{rst, vv, iv, trf, dir} = 5'h10;
		vin = 16'h0000;
		iin = 16'h0000;
		ext = 16'h0000;
		pen = 16'h0000;
		pf = 2'h3;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		t_reset_vals();
		t_force();
		t_enables();
		t_ext();
		t_vin();
		t_iin();
		t_idle();
		give_verdict();
	end
endmodule
`default_nettype wire
